//--- src/lpcd_defines.vh
// Constants of the legacy LPC transfer controller: register offsets, fields, reset values.
// Included by bare name by the controller only; the priority picker does not include it; definitions only.
`ifndef LPCD_DEFINES_VH
`define LPCD_DEFINES_VH

// Register offsets (word index on regAddr)
`define LPCD_OFS_ADDR 8'h00
`define LPCD_OFS_CNT 8'h08
`define LPCD_OFS_CMD0 8'h10
`define LPCD_OFS_CMD1 8'h11
`define LPCD_OFS_MODE0 8'h12
`define LPCD_OFS_MODE1 8'h13
`define LPCD_OFS_MASK 8'h14
`define LPCD_OFS_STAT 8'h15
`define LPCD_OFS_MODERD 8'h18

// Command fields
`define LPCD_CMD_EN_BIT 2
`define LPCD_CMD_PRIO_BIT 4

// Mode fields
`define LPCD_MODE_SVC_HI 7
`define LPCD_MODE_SVC_LO 6
`define LPCD_MODE_AUTO_BIT 4
`define LPCD_MODE_TYPE_HI 3
`define LPCD_MODE_TYPE_LO 2
`define LPCD_MODE_SEL_HI 1
`define LPCD_MODE_SEL_LO 0

// Service and type codes
`define LPCD_SVC_DEMAND 2'h0
`define LPCD_SVC_SINGLE 2'h1
`define LPCD_TYPE_VERIFY 2'h0
`define LPCD_TYPE_WRITE 2'h1
`define LPCD_TYPE_READ 2'h2
`define LPCD_TYPE_ILLEGAL 2'h3

// Channel roles
`define LPCD_CASCADE_CH 3'h4
`define LPCD_WIDE_FIRST 3'h4

// Reset values
`define LPCD_RST_CMD 8'h00
`define LPCD_RST_MODE 8'h00
`define LPCD_RST_MASK 8'hFF
`define LPCD_RST_WORD 16'h0000

`endif

//--- src/lpcd_prio_arb.v
// Fixed-priority picker: lowest-numbered requesting channel wins.
// Assumes requests are already synchronised to sys_clk; purely combinational.
`timescale 1ns/1ps
module lpcd_prio_arb #(
  parameter NCH = 8
) (
  input wire [NCH-1:0] reqVec,
  output wire [NCH-1:0] grantVec,
  output reg [2:0] grantIdx,
  output wire anyReq
);
  wire [NCH:0] blockVec;
  integer k;

  assign blockVec[0] = 1'b0;
  assign anyReq = blockVec[NCH];

  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1) begin : gPrio
      // No rotation: position in the vector alone decides
      assign grantVec[i] = reqVec[i] & ~blockVec[i];
      assign blockVec[i+1] = blockVec[i] | reqVec[i];
    end
  endgenerate

  always @* begin
    grantIdx = 3'h0;
    for (k = NCH - 1; k >= 0; k = k - 1) begin
      if (grantVec[k]) begin
        grantIdx = k[2:0];
      end
    end
  end
endmodule

//--- src/lpcd_controller.v
// Legacy LPC transfer controller: eight channel slots, seven usable, fixed priority.
// Assumes a same-clock register port and a same-clock LPC cycle engine answering xferDone.
// Notes on behaviour
// - Single and demand service, verify transfers, incrementing addresses are supported.
// - No block service, no decrement, no cascade on ordinary channels.
// - No memory-to-memory transfers; no external end-of-process input exists.
// - Exactly seven usable channels across both controller halves.
// - Channels 0 to 3 move one byte per transfer.
// - Channels 5 to 7 move 16-bit words; never 32-bit.
// - LPC bus-master requests arrive on channel 4 and are routed there.
// - Channel 4 address and count registers exist but are never used.
// - Only command bit 2 acts: it enables or disables its half.
// - Arbitration is always fixed priority; command bit 4 is ignored.
// - Mode bits 7:6: 00 demand, 01 single, 10 and 11 obsolete.
// - Channel 4 is always cascade, whatever its mode holds.
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "lpcd_defines.vh"
module lpcd_controller #(
  parameter NCH = 8
) (
  input wire sys_clk,
  input wire nrst,
  input wire [7:0] regAddr,
  input wire [15:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [15:0] regRdData,
  input wire [NCH-1:0] chanReqPin,
  output wire xferValid,
  output reg [2:0] xferChan,
  output reg [15:0] xferAddr,
  output reg xferWide,
  output reg [1:0] xferType,
  output reg xferLast,
  input wire xferDone,
  output wire cascadeGrant
);
  localparam ST_IDLE = 2'h0;
  localparam ST_XFER = 2'h1;
  localparam ST_CASC = 2'h2;

  reg [15:0] baseAddr_q [0:NCH-1];
  reg [15:0] baseCnt_q [0:NCH-1];
  reg [15:0] curAddr_q [0:NCH-1];
  reg [15:0] curCnt_q [0:NCH-1];
  reg [7:0] mode_q [0:NCH-1];
  reg [7:0] cmd0_q;
  reg [7:0] cmd1_q;
  reg [NCH-1:0] mask_q;
  reg [NCH-1:0] tcFlag_q;
  reg [NCH-1:0] reqMeta_q;
  reg [NCH-1:0] reqSync_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [2:0] chan_q;
  integer n;

  wire [2:0] regIdx = regAddr[2:0];
  wire wrAddr = regWr & (regAddr[7:3] == `LPCD_OFS_ADDR >> 3);
  wire wrCnt = regWr & (regAddr[7:3] == `LPCD_OFS_CNT >> 3);
  wire wrMode0 = regWr & (regAddr == `LPCD_OFS_MODE0);
  wire wrMode1 = regWr & (regAddr == `LPCD_OFS_MODE1);
  wire rdStat = regRd & (regAddr == `LPCD_OFS_STAT);

  // Only bit 2 of each command register is ever looked at
  wire half0En = cmd0_q[`LPCD_CMD_EN_BIT];
  wire half1En = cmd1_q[`LPCD_CMD_EN_BIT];

  // Channel picked by mode bits 1:0, offset by half
  wire [2:0] modeTarget = {wrMode1, regWrData[`LPCD_MODE_SEL_HI:`LPCD_MODE_SEL_LO]};

  // Eligibility per channel
  wire [NCH-1:0] eligible;
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : gElig
      wire [1:0] chType = mode_q[g][`LPCD_MODE_TYPE_HI:`LPCD_MODE_TYPE_LO];
      wire halfEn = (g < 4) ? half0En : half1En;
      if (g == 4) begin : gCasc
        // Bus-master requests: type and service fields do not matter
        assign eligible[g] = reqSync_q[g] & ~mask_q[g] & halfEn;
      end else begin : gNorm
        // Illegal type keeps the channel from being serviced
        assign eligible[g] = reqSync_q[g] & ~mask_q[g] & halfEn & (chType != `LPCD_TYPE_ILLEGAL);
      end
    end
  endgenerate

  wire [NCH-1:0] grantVec;
  wire [2:0] grantIdx;
  wire anyReq;

  lpcd_prio_arb #(
    .NCH(NCH)
  ) uArb (
    .reqVec(eligible),
    .grantVec(grantVec),
    .grantIdx(grantIdx),
    .anyReq(anyReq)
  );

  // Current channel view
  wire [7:0] chMode = mode_q[chan_q];
  wire [1:0] chSvc = chMode[`LPCD_MODE_SVC_HI:`LPCD_MODE_SVC_LO];
  wire chAuto = chMode[`LPCD_MODE_AUTO_BIT];
  wire chTc = (curCnt_q[chan_q] == 16'h0000);
  wire doneNow = (state_q == ST_XFER) & xferDone;
  // Obsolete codes 10 and 11 fall back to single service
  wire chDemand = (chSvc == `LPCD_SVC_DEMAND);
  wire stayOn = chDemand & ~chTc & eligible[chan_q] & grantVec[chan_q];
  // Always count up; no decrement path exists
  wire [15:0] nextAddr = curAddr_q[chan_q] + 16'h0001;
  wire [15:0] nextCnt = curCnt_q[chan_q] - 16'h0001;

  assign xferValid = (state_q == ST_XFER);
  assign cascadeGrant = (state_q == ST_CASC);

  // Request pins come from outside the clock domain
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reqMeta_q <= {NCH{1'b0}};
      reqSync_q <= {NCH{1'b0}};
    end else begin
      reqMeta_q <= chanReqPin;
      reqSync_q <= reqMeta_q;
    end
  end

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (anyReq) begin
          // Channel 4 never runs a transfer of its own
          state_d = (grantIdx == `LPCD_CASCADE_CH) ? ST_CASC : ST_XFER;
        end
      end
      ST_XFER: begin
        if (xferDone && !stayOn) begin
          state_d = ST_IDLE;
        end
      end
      ST_CASC: begin
        if (!eligible[`LPCD_CASCADE_CH]) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      chan_q <= 3'h0;
      xferChan <= 3'h0;
      xferAddr <= `LPCD_RST_WORD;
      xferWide <= 1'b0;
      xferType <= `LPCD_TYPE_VERIFY;
      xferLast <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q == ST_IDLE && anyReq) begin
        chan_q <= grantIdx;
        xferChan <= grantIdx;
        xferAddr <= curAddr_q[grantIdx];
        // Word width for channels 5 to 7, byte for 0 to 4
        xferWide <= (grantIdx > `LPCD_WIDE_FIRST);
        // Only peripheral-to-memory style types; no memory-to-memory path, no end-of-process pin
        xferType <= mode_q[grantIdx][`LPCD_MODE_TYPE_HI:`LPCD_MODE_TYPE_LO];
        xferLast <= (curCnt_q[grantIdx] == 16'h0000);
      end else if (doneNow && stayOn) begin
        xferAddr <= nextAddr;
        xferLast <= (nextCnt == 16'h0000);
      end
    end
  end

  // Register file and per-channel progress
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (n = 0; n < NCH; n = n + 1) begin
        baseAddr_q[n] <= `LPCD_RST_WORD;
        baseCnt_q[n] <= `LPCD_RST_WORD;
        curAddr_q[n] <= `LPCD_RST_WORD;
        curCnt_q[n] <= `LPCD_RST_WORD;
        mode_q[n] <= `LPCD_RST_MODE;
      end
      cmd0_q <= `LPCD_RST_CMD;
      cmd1_q <= `LPCD_RST_CMD;
      mask_q <= `LPCD_RST_MASK;
      tcFlag_q <= {NCH{1'b0}};
    end else begin
      // Channel 4 words are storage only; nothing below reads them for transfers
      if (wrAddr) begin
        baseAddr_q[regIdx] <= regWrData;
        curAddr_q[regIdx] <= regWrData;
      end
      if (wrCnt) begin
        baseCnt_q[regIdx] <= regWrData;
        curCnt_q[regIdx] <= regWrData;
      end
      if (wrMode0 || wrMode1) begin
        mode_q[modeTarget] <= regWrData[7:0];
      end
      if (regWr && regAddr == `LPCD_OFS_CMD0) begin
        cmd0_q <= regWrData[7:0];
      end
      if (regWr && regAddr == `LPCD_OFS_CMD1) begin
        cmd1_q <= regWrData[7:0];
      end
      if (regWr && regAddr == `LPCD_OFS_MASK) begin
        mask_q <= regWrData[NCH-1:0];
      end
      if (rdStat) begin
        tcFlag_q <= {NCH{1'b0}};
      end
      // Hardware updates come last so they win over a same-cycle access
      if (doneNow) begin
        if (chTc) begin
          tcFlag_q[chan_q] <= 1'b1;
          if (chAuto) begin
            curAddr_q[chan_q] <= baseAddr_q[chan_q];
            curCnt_q[chan_q] <= baseCnt_q[chan_q];
          end else begin
            curAddr_q[chan_q] <= nextAddr;
            curCnt_q[chan_q] <= nextCnt;
            mask_q[chan_q] <= 1'b1;
          end
        end else begin
          curAddr_q[chan_q] <= nextAddr;
          curCnt_q[chan_q] <= nextCnt;
        end
      end
    end
  end

  // Read data in the cycle after the strobe; unmapped reads give zero
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      regRdData <= `LPCD_RST_WORD;
    end else if (regRd) begin
      if (regAddr[7:3] == `LPCD_OFS_ADDR >> 3) begin
        regRdData <= curAddr_q[regIdx];
      end else if (regAddr[7:3] == `LPCD_OFS_CNT >> 3) begin
        regRdData <= curCnt_q[regIdx];
      end else if (regAddr[7:3] == `LPCD_OFS_MODERD >> 3) begin
        regRdData <= {8'h00, mode_q[regIdx]};
      end else if (regAddr == `LPCD_OFS_CMD0) begin
        regRdData <= {8'h00, cmd0_q};
      end else if (regAddr == `LPCD_OFS_CMD1) begin
        regRdData <= {8'h00, cmd1_q};
      end else if (regAddr == `LPCD_OFS_MASK) begin
        regRdData <= {8'h00, mask_q};
      end else if (rdStat) begin
        regRdData <= {reqSync_q, tcFlag_q};
      end else begin
        regRdData <= `LPCD_RST_WORD;
      end
    end else begin
      regRdData <= `LPCD_RST_WORD;
    end
  end
endmodule

//--- verification/lpcd_controller_sva.sv
// Port checker for the transfer controller.
// Assumes one clock domain and the bind below.
`timescale 1ns/1ps
module lpcd_controller_sva #(
  parameter NCH = 8
) (
  input wire sys_clk,
  input wire nrst,
  input wire [NCH-1:0] chanReqPin,
  input wire xferValid,
  input wire [2:0] xferChan,
  input wire [15:0] xferAddr,
  input wire xferWide,
  input wire [1:0] xferType,
  input wire xferLast,
  input wire xferDone,
  input wire cascadeGrant
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  a_no_ch4: assert property (xferValid |-> xferChan != 3'h4) else $error("ch4 moved data");
  a_wide_map: assert property (xferValid |-> xferWide == (xferChan > 3'h4)) else $error("bad width");
  a_type_ok: assert property (xferValid |-> xferType != 2'h3) else $error("bad type");
  a_hold_xfer: assert property (xferValid && !xferDone |=> xferValid && $stable(xferAddr)
    && $stable({xferChan, xferType, xferLast})) else $error("transfer moved");
  a_addr_step: assert property (xferValid && xferDone && !xferLast |=> !xferValid
    || (xferAddr == $past(xferAddr) + 16'h0001 && $stable(xferChan))) else $error("bad step");
  a_last_idle: assert property (xferValid && xferDone && xferLast |=> !xferValid) else $error("ran on");
  a_one_owner: assert property (!(xferValid && cascadeGrant)) else $error("two owners");
  a_casc_drop: assert property (cascadeGrant && !chanReqPin[4] |-> ##[1:4] !cascadeGrant)
    else $error("grant stuck");
  c_last: cover property (xferValid && xferDone && xferLast);
  c_wide: cover property (xferValid && xferDone && xferWide);
  c_casc: cover property (cascadeGrant);
endmodule
bind lpcd_controller lpcd_controller_sva #(.NCH(NCH)) u_sva (.sys_clk(sys_clk), .nrst(nrst),
  .chanReqPin(chanReqPin), .xferValid(xferValid), .xferChan(xferChan), .xferAddr(xferAddr),
  .xferWide(xferWide), .xferType(xferType), .xferLast(xferLast), .xferDone(xferDone),
  .cascadeGrant(cascadeGrant));

//--- verification/lpcd_periph_model.sv
// Peripheral side: holds requests, answers each transfer 2 to 5 cycles after xferValid.
// Assumes the controller's clock; the bench sets and clears requests.
`timescale 1ns/1ps
module lpcd_periph_model (
  input wire sys_clk,
  input wire nrst,
  input wire [7:0] reqSet,
  input wire [7:0] reqClr,
  input wire xferValid,
  input wire [2:0] xferChan,
  input wire xferLast,
  output wire [7:0] chanReqPin,
  output wire xferDone
);
  reg [7:0] req_q;
  reg done_q;
  reg busy_q;
  reg [1:0] wait_q;
  assign chanReqPin = req_q;
  assign xferDone = done_q;
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      req_q <= 8'h00;
      done_q <= 1'b0;
      busy_q <= 1'b0;
      wait_q <= 2'h0;
    end else begin
      // Drop early on the last one, ahead of the synchroniser lag
      req_q <= (req_q | reqSet) & ~reqClr & ~(xferValid && xferLast ? 8'h01 << xferChan : 8'h00);
      done_q <= busy_q && wait_q == 2'h0;
      if (busy_q) begin
        busy_q <= wait_q != 2'h0;
        wait_q <= wait_q - 2'h1;
      end else if (xferValid && !done_q) begin
        busy_q <= 1'b1;
        wait_q <= 2'($urandom % 4);
      end
    end
  end
endmodule

//--- verification/lpcd_controller_tb_top.sv
// Bench: register tasks, queue model of transfers, peripheral model.
// Assumes the checker binds itself.
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin errors++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module lpcd_controller_tb_top;
  logic sys_clk = 0, nrst = 0, regWr = 0, regRd = 0;
  logic [7:0] regAddr = 0, reqSet = 0, reqClr = 0, msk = 8'hFF, tc = 0;
  logic [15:0] regWrData = 0, a;
  logic [22:0] q[$], e;
  logic [1:0] en = 0;
  logic [15:0] base[8];
  logic [1:0] cn[8];
  logic [7:0] md[8];
  int errors = 0, tests_run = 0, cyc = 0;
  wire [15:0] regRdData, xferAddr;
  wire [7:0] chanReqPin;
  wire [2:0] xferChan;
  wire [1:0] xferType;
  wire xferValid, xferWide, xferLast, xferDone, cascadeGrant;
  always #5 sys_clk = ~sys_clk;
  lpcd_controller #(.NCH(8)) dut (.sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .chanReqPin(chanReqPin), .xferValid(xferValid),
    .xferChan(xferChan), .xferAddr(xferAddr), .xferWide(xferWide), .xferType(xferType),
    .xferLast(xferLast), .xferDone(xferDone), .cascadeGrant(cascadeGrant));
  lpcd_periph_model pm (.sys_clk(sys_clk), .nrst(nrst), .reqSet(reqSet), .reqClr(reqClr),
    .xferValid(xferValid), .xferChan(xferChan), .xferLast(xferLast), .chanReqPin(chanReqPin), .xferDone(xferDone));
  task end_of_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task wr(input [7:0] ad, input [15:0] d);
    @(posedge sys_clk);
    regWr <= 1;
    regAddr <= ad;
    regWrData <= d;
    @(posedge sys_clk);
    regWr <= 0;
  endtask
  task rd(input [7:0] ad, input [15:0] x);
    @(posedge sys_clk);
    regRd <= 1;
    regAddr <= ad;
    @(posedge sys_clk);
    regRd <= 0;
    #1 `CHK("read", x, regRdData)
  endtask
  task cmd(input h, input [7:0] v);
    wr(8'h10 + h, {8'h00, v});
    en[h] = v[2];
  endtask
  task setup(input [2:0] c, input [7:0] m);
    logic mv;
    mv = en[c[2]] && m[3:2] != 2'h3;
    a = $urandom;
    base[c] = a;
    md[c] = m;
    cn[c] = 2'($urandom % 4);
    wr(8'h00 + c, a);
    wr(8'h08 + c, {14'h0, cn[c]});
    wr(8'h12 + c[2], {8'h00, m | c[1:0]});
    rd(8'h18 + c, {8'h00, m | c[1:0]});
    msk[c] = 0;
    wr(8'h14, {8'h00, msk});
    for (int k = 0; k <= cn[c]; k++)
      if (mv) q.push_back({c, a + 16'(k), c > 3'h4, m[3:2], k == cn[c]});
    if (mv) tc[c] = 1;
  endtask
  task go(input [7:0] s);
    logic mv;
    @(posedge sys_clk);
    reqSet <= s;
    @(posedge sys_clk);
    reqSet <= 0;
    for (int i = 0; i < 99 && q.size() > 0; i++) @(posedge sys_clk);
    repeat (20) @(posedge sys_clk);
    reqClr <= 8'hFF;
    @(posedge sys_clk);
    reqClr <= 0;
    `CHK("left", 0, q.size())
    for (int i = 0; i < 8; i++) if (s[i]) begin
      mv = en[i / 4] && md[i][3:2] != 2'h3 && !md[i][4];
      if (mv) msk[i] = 1;
      rd(i[7:0], mv ? base[i] + cn[i] + 16'h0001 : base[i]);
      rd(8'h08 + i[7:0], mv ? 16'hFFFF : {14'h0, cn[i]});
    end
    rd(8'h14, {8'h00, msk});
    rd(8'h15, {8'h00, tc});
    tc = 0;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_of_test;
    end
    if (xferValid && xferDone) begin
      e = q.size() ? q.pop_front() : 23'h7FFFFF;
      `CHK("xfer", e, {xferChan, xferAddr, xferWide, xferType, xferLast})
    end
  end
  initial begin
    void'($urandom(21));
    repeat (6) @(posedge sys_clk);
    nrst <= 1;
    rd(8'h14, 16'h00FF);
    rd(8'h10, 16'h0000);
    wr(8'h16, 16'hFFFF);
    rd(8'h16, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      a = $urandom;
      wr(i[7:0], a);
      rd(i[7:0], a);
    end
    cmd(1, 8'h04);
    cmd(0, 8'hFB);
    setup(0, 8'h44);
    go(8'h01);
    cmd(0, 8'h14);
    setup(1, 8'h08);
    go(8'h02);
    setup(2, 8'h4C);
    go(8'h04);
    setup(3, 8'h80);
    go(8'h08);
    setup(5, 8'hC4);
    go(8'h20);
    setup(7, 8'h58);
    go(8'h80);
    setup(6, 8'h04);
    go(8'h40);
    setup(1, 8'h44);
    setup(3, 8'h44);
    go(8'h0A);
    wr(8'h13, 16'h0044);
    msk[4] = 0;
    wr(8'h14, {8'h00, msk});
    @(posedge sys_clk);
    reqSet <= 8'h10;
    @(posedge sys_clk);
    reqSet <= 0;
    repeat (4) @(posedge sys_clk);
    #1 `CHK("grant", 1'b1, cascadeGrant)
    reqClr <= 8'h10;
    repeat (5) @(posedge sys_clk);
    #1 `CHK("grant", 1'b0, cascadeGrant)
    end_of_test;
  end
endmodule
